// File: inc/epi_pkg.sv
// Purpose: shared constants and types of the external pin interrupt unit
// Assumes: 8-bit registers on a 32-bit APB, one word per register
// Notes: byte address of a register is four times its index
package epi_pkg;

    // ------------------------------------------------------------------
    // register indices (byte address = index * 4)
    // ------------------------------------------------------------------
    localparam logic [5:0] IDX_CTRL = 6'h35;      // sleep_and_sense_control
    localparam logic [5:0] IDX_MASK_LOW = 6'h12;  // pin_change_mask_low
    localparam logic [5:0] IDX_MASK_HIGH = 6'h13; // pin_change_mask_high
    localparam logic [5:0] IDX_FLAG = 6'h3a;      // flag register
    localparam logic [5:0] IDX_ENABLE = 6'h3b;    // interrupt_group_enable

    // ------------------------------------------------------------------
    // field layout, writable masks and reset values
    // ------------------------------------------------------------------
    localparam logic [7:0] CTRL_RW_MASK = 8'h7b;      // bits 7 and 2 read zero
    localparam logic [7:0] GRP_RW_MASK = 8'h70;       // bits 7 and 3..0 read zero
    localparam logic [7:0] MASK_HIGH_RW_MASK = 8'h0f; // only pins 11..8
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam int EXT_BIT = 6;                       // enable and flag bit
    localparam int GRP_HIGH_BIT = 5;
    localparam int GRP_LOW_BIT = 4;
    localparam int SLEEP_LSB = 3;                     // sleep controls 6..3

    // sense select codes
    localparam logic [1:0] SENSE_LOW = 2'b00;
    localparam logic [1:0] SENSE_ANY = 2'b01;
    localparam logic [1:0] SENSE_FALL = 2'b10;
    localparam logic [1:0] SENSE_RISE = 2'b11;

    // ------------------------------------------------------------------
    // vector word addresses
    // ------------------------------------------------------------------
    localparam int NUM_VEC = 17;
    localparam logic [4:0] VEC_RESET = 5'h00;
    localparam logic [4:0] VEC_EXT = 5'h01;
    localparam logic [4:0] VEC_GRP_LOW = 5'h02;
    localparam logic [4:0] VEC_GRP_HIGH = 5'h03;
    localparam logic [4:0] VEC_WDT = 5'h04;       // then t16 capt, cmpa, cmpb, ovf
    localparam logic [4:0] VEC_T8_CMPA = 5'h09;   // then t8 cmpb, ovf
    localparam logic [4:0] VEC_ANA_COMP = 5'h0c;  // then adc, eeprom, serial start
    localparam logic [4:0] VEC_SER_OVF = 5'h10;

    // per-source bit group carried between processes
    typedef struct packed {
        logic ext;
        logic grp_high;
        logic grp_low;
    } epi_src_t;

    // dispatch states, one-hot
    typedef enum logic [1:0] {
        EPI_ST_IDLE = 2'b01,
        EPI_ST_OFFER = 2'b10
    } epi_state_t;

    // true when a byte address hits a register index
    function automatic logic epi_addr_is(input logic [7:0] addr, input logic [5:0] idx);
        return addr == {idx, 2'b00};
    endfunction : epi_addr_is

endpackage : epi_pkg

// File: hdl/epi_vector_arbiter.sv
// Purpose: fixed-priority pick of the pending vector
// Assumes: bit n of the request word is vector word address n
// Notes: purely combinational, the top registers the result
`timescale 1ns/1ps
module epi_vector_arbiter (
    input wire logic [16:0] req,
    output logic valid,
    output logic [4:0] vec
);

    // ------------------------------------------------------------------
    // lowest address wins
    // ------------------------------------------------------------------
    function automatic logic [4:0] lowest_set(input logic [16:0] r);
        logic [4:0] pick;
        pick = 5'h00;
        for (int i = epi_pkg::NUM_VEC - 1; i >= 0; i--) begin
            if (r[i]) begin
                pick = 5'(i); // later hits are lower, so they overwrite
            end
        end
        return pick;
    endfunction : lowest_set

    // reset at address zero naturally beats every interrupt
    always_comb begin
        valid = |req;
        vec = lowest_set(req);
    end

endmodule : epi_vector_arbiter

// File: hdl/epi_top.sv
// Purpose: external request pin and pin-change interrupt unit with vector dispatch
// Assumes: pins synchronous to clk; io_clk_en low while the i/o clock is stopped
// Notes: clk stays alive in sleep; edge sensing and level requests need the i/o clock
//
// What this block does
// - every reset source dispatches vector zero
// - external, group low, group high at 1-3
// - watchdog at 4, 16-bit timer 5..8
// - 8-bit timer, comparator, adc, eeprom, serial 9..16
// - pins driven as outputs still interrupt
// - groups fire on unmasked pin toggles
// - pin-change detection needs no i/o clock
// - sense codes: low, any, falling, rising
// - low level keeps re-raising while low
// - edge sensing runs only with i/o clock
// - low level wakes without i/o clock
// - level must outlast start-up to interrupt
// - pin sampled first; longer pulses always caught
// - external vector needs its enable and global
// - group high needs bit 5 and global
// - reserved bits read zero
// - group low needs bit 4 and global
// - external flag: set, clear on entry/one
// - group flags: set, clear on entry/one
`timescale 1ns/1ps
module epi_top (
    input wire logic clk,
    input wire logic resetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic external_request_line,
    input wire logic [11:0] pin_change_inputs,
    input wire logic io_clk_en,
    input wire logic global_int_flag,
    input wire logic vector_taken,
    input wire logic [3:0] reset_sources,
    input wire logic [12:0] peripheral_requests,
    output logic irq_request,
    output logic [4:0] irq_vector,
    output logic wake_request,
    output logic [3:0] sleep_controls
);

    // ------------------------------------------------------------------
    // reset release
    // ------------------------------------------------------------------
    logic rst_meta_ff; // first stage, read only by the second
    logic rst_n;       // synchronised reset used everywhere else

    // async assert, release through two flops
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rst_meta_ff <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta_ff <= 1'b1;
            rst_n <= rst_meta_ff;
        end
    end

    // ------------------------------------------------------------------
    // state declarations
    // ------------------------------------------------------------------
    logic [7:0] ctrl_ff;        // sense select and sleep controls
    logic [7:0] mask_low_ff;    // pins 7..0
    logic [7:0] mask_high_ff;   // pins 11..8 in bits 3..0
    epi_pkg::epi_src_t en_ff;   // group enables
    epi_pkg::epi_src_t flags_ff;
    epi_pkg::epi_src_t nxt_flags;
    logic ext_s_ff;             // sampled request pin
    logic ext_p_ff;             // previous sample
    logic [11:0] pc_prev_ff;    // last seen pin-change levels
    logic [31:0] prdata_ff;
    logic pready_ff;
    logic pslverr_ff;
    logic irq_request_ff;
    logic [4:0] irq_vector_ff;
    logic wake_ff;
    epi_pkg::epi_state_t state_ff;
    logic [1:0] sense;
    logic ext_edge;
    logic ext_level_req;
    logic [11:0] pc_change;
    logic grp_low_hit;
    logic grp_high_hit;
    logic [16:0] req_vec;
    logic arb_valid;
    logic [4:0] arb_vec;
    logic wr_access;            // write taken this edge
    logic setup_phase;
    logic entry;                // core enters the offered vector

    assign sense = ctrl_ff[1:0];
    assign setup_phase = psel && !penable;
    assign wr_access = psel && penable && pready_ff && pwrite && pstrb[0];
    assign entry = (state_ff == epi_pkg::EPI_ST_OFFER) && vector_taken;

    // ------------------------------------------------------------------
    // apb slave: answer one cycle after setup, no wait beyond that
    // ------------------------------------------------------------------
    // read data and error are prepared in the setup cycle
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prdata_ff <= 32'h0000_0000;
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
        end else begin
            pready_ff <= setup_phase;
            pslverr_ff <= 1'b0;
            prdata_ff <= 32'h0000_0000;
            if (setup_phase) begin
                if (epi_pkg::epi_addr_is(paddr, epi_pkg::IDX_CTRL)) begin
                    prdata_ff[7:0] <= ctrl_ff & epi_pkg::CTRL_RW_MASK;
                end else if (epi_pkg::epi_addr_is(paddr, epi_pkg::IDX_ENABLE)) begin
                    // reserved enable bits come out as zero
                    prdata_ff[epi_pkg::EXT_BIT] <= en_ff.ext;
                    prdata_ff[epi_pkg::GRP_HIGH_BIT] <= en_ff.grp_high;
                    prdata_ff[epi_pkg::GRP_LOW_BIT] <= en_ff.grp_low;
                end else if (epi_pkg::epi_addr_is(paddr, epi_pkg::IDX_FLAG)) begin
                    prdata_ff[epi_pkg::EXT_BIT] <= flags_ff.ext;
                    prdata_ff[epi_pkg::GRP_HIGH_BIT] <= flags_ff.grp_high;
                    prdata_ff[epi_pkg::GRP_LOW_BIT] <= flags_ff.grp_low;
                end else if (epi_pkg::epi_addr_is(paddr, epi_pkg::IDX_MASK_LOW)) begin
                    prdata_ff[7:0] <= mask_low_ff;
                end else if (epi_pkg::epi_addr_is(paddr, epi_pkg::IDX_MASK_HIGH)) begin
                    prdata_ff[7:0] <= mask_high_ff & epi_pkg::MASK_HIGH_RW_MASK;
                end else begin
                    pslverr_ff <= 1'b1; // unmapped address
                end
            end
        end
    end

    // configuration writes; only lane 0 carries the byte
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_ff <= epi_pkg::REG_RESET;
            mask_low_ff <= epi_pkg::REG_RESET;
            mask_high_ff <= epi_pkg::REG_RESET;
            en_ff <= '0;
        end else if (wr_access) begin
            if (epi_pkg::epi_addr_is(paddr, epi_pkg::IDX_CTRL)) begin
                ctrl_ff <= pwdata[7:0] & epi_pkg::CTRL_RW_MASK;
            end
            if (epi_pkg::epi_addr_is(paddr, epi_pkg::IDX_ENABLE)) begin
                en_ff.ext <= pwdata[epi_pkg::EXT_BIT];
                en_ff.grp_high <= pwdata[epi_pkg::GRP_HIGH_BIT];
                en_ff.grp_low <= pwdata[epi_pkg::GRP_LOW_BIT];
            end
            if (epi_pkg::epi_addr_is(paddr, epi_pkg::IDX_MASK_LOW)) begin
                mask_low_ff <= pwdata[7:0];
            end
            if (epi_pkg::epi_addr_is(paddr, epi_pkg::IDX_MASK_HIGH)) begin
                mask_high_ff <= pwdata[7:0] & epi_pkg::MASK_HIGH_RW_MASK;
            end
        end
    end

    // ------------------------------------------------------------------
    // request pin sampling and sensing
    // ------------------------------------------------------------------
    // samples only advance while the i/o clock runs, so edges cannot wake deep sleep
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ext_s_ff <= 1'b1;
            ext_p_ff <= 1'b1;
        end else if (io_clk_en) begin
            ext_s_ff <= external_request_line;
            ext_p_ff <= ext_s_ff;
        end
    end

    // edge decode on sampled values; a pulse over one period is always seen
    always_comb begin
        ext_edge = 1'b0;
        unique case (sense)
            epi_pkg::SENSE_LOW: ext_edge = 1'b0;
            epi_pkg::SENSE_ANY: ext_edge = ext_s_ff ^ ext_p_ff;
            epi_pkg::SENSE_FALL: ext_edge = ext_p_ff && !ext_s_ff;
            epi_pkg::SENSE_RISE: ext_edge = !ext_p_ff && ext_s_ff;
        endcase
        ext_edge = ext_edge && io_clk_en;
    end

    // level requests look at the raw pin; they need the core awake, so a level
    // gone before start-up ends still wakes but never requests
    assign ext_level_req = (sense == epi_pkg::SENSE_LOW) && en_ff.ext && global_int_flag
                           && io_clk_en && !external_request_line;

    // ------------------------------------------------------------------
    // pin-change detection
    // ------------------------------------------------------------------
    // the pin level is seen whatever drives it, so software can toggle an output
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pc_prev_ff <= 12'h000;
        end else begin
            pc_prev_ff <= pin_change_inputs;
        end
    end

    assign pc_change = pin_change_inputs ^ pc_prev_ff;
    assign grp_low_hit = |(pc_change[7:0] & mask_low_ff);
    assign grp_high_hit = |(pc_change[11:8] & mask_high_ff[3:0]);

    // ------------------------------------------------------------------
    // flags: write one or vector entry clears, a new event wins
    // ------------------------------------------------------------------
    always_comb begin
        nxt_flags = flags_ff;
        if (wr_access && epi_pkg::epi_addr_is(paddr, epi_pkg::IDX_FLAG)) begin
            nxt_flags.ext = nxt_flags.ext && !pwdata[epi_pkg::EXT_BIT];
            nxt_flags.grp_high = nxt_flags.grp_high && !pwdata[epi_pkg::GRP_HIGH_BIT];
            nxt_flags.grp_low = nxt_flags.grp_low && !pwdata[epi_pkg::GRP_LOW_BIT];
        end
        if (entry) begin
            // entry clears only the flag of the vector the core took
            if (irq_vector_ff == epi_pkg::VEC_EXT) begin
                nxt_flags.ext = 1'b0;
            end
            if (irq_vector_ff == epi_pkg::VEC_GRP_LOW) begin
                nxt_flags.grp_low = 1'b0;
            end
            if (irq_vector_ff == epi_pkg::VEC_GRP_HIGH) begin
                nxt_flags.grp_high = 1'b0;
            end
        end
        nxt_flags.ext = nxt_flags.ext || ext_edge;
        nxt_flags.grp_low = nxt_flags.grp_low || grp_low_hit;
        nxt_flags.grp_high = nxt_flags.grp_high || grp_high_hit;
        if (sense == epi_pkg::SENSE_LOW) begin
            nxt_flags.ext = 1'b0; // level mode never holds the flag
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            flags_ff <= '0;
        end else begin
            flags_ff <= nxt_flags;
        end
    end

    // ------------------------------------------------------------------
    // request word and dispatch
    // ------------------------------------------------------------------
    // reset ignores the global flag; everything else needs it
    always_comb begin
        req_vec = 17'h00000;
        req_vec[epi_pkg::VEC_RESET] = |reset_sources;
        req_vec[epi_pkg::VEC_EXT] = (flags_ff.ext && en_ff.ext && global_int_flag)
                                    || ext_level_req;
        req_vec[epi_pkg::VEC_GRP_LOW] = flags_ff.grp_low && en_ff.grp_low
                                        && global_int_flag;
        req_vec[epi_pkg::VEC_GRP_HIGH] = flags_ff.grp_high && en_ff.grp_high
                                         && global_int_flag;
        // watchdog, timers, comparator, adc, eeprom, serial in table order
        req_vec[epi_pkg::VEC_SER_OVF:epi_pkg::VEC_WDT] = peripheral_requests
                                                         & {13{global_int_flag}};
    end

    epi_vector_arbiter u_arb (
        .req(req_vec),
        .valid(arb_valid),
        .vec(arb_vec)
    );

    // offer tracks the best pending vector until the core takes it
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_ff <= epi_pkg::EPI_ST_IDLE;
        end else begin
            unique case (state_ff)
                epi_pkg::EPI_ST_IDLE: begin
                    if (arb_valid) begin
                        state_ff <= epi_pkg::EPI_ST_OFFER;
                    end
                end
                epi_pkg::EPI_ST_OFFER: begin
                    // taken, or withdrawn (level released, global cleared)
                    if (vector_taken || !arb_valid) begin
                        state_ff <= epi_pkg::EPI_ST_IDLE;
                    end
                end
                default: state_ff <= epi_pkg::EPI_ST_IDLE;
            endcase
        end
    end

    // vector output; the core samples it with irq_request high
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_request_ff <= 1'b0;
            irq_vector_ff <= epi_pkg::VEC_RESET;
        end else if (entry || !arb_valid) begin
            irq_request_ff <= 1'b0; // one idle cycle after entry lets flags settle
        end else begin
            irq_request_ff <= 1'b1;
            irq_vector_ff <= arb_vec;
        end
    end

    // ------------------------------------------------------------------
    // wake and sleep controls
    // ------------------------------------------------------------------
    // level and pin-change wake do not depend on io_clk_en
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wake_ff <= 1'b0;
        end else begin
            wake_ff <= (en_ff.ext && (sense == epi_pkg::SENSE_LOW) && !external_request_line)
                       || (en_ff.grp_low && (flags_ff.grp_low || grp_low_hit))
                       || (en_ff.grp_high && (flags_ff.grp_high || grp_high_hit));
        end
    end

    assign prdata = prdata_ff;
    assign pready = pready_ff;
    assign pslverr = pslverr_ff;
    assign irq_request = irq_request_ff;
    assign irq_vector = irq_vector_ff;
    assign wake_request = wake_ff;
    assign sleep_controls = ctrl_ff[epi_pkg::SLEEP_LSB +: 4];

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    property p_reset_vec;
        (|reset_sources && !entry) |=> (irq_request_ff && irq_vector_ff == 5'h00);
    endproperty
    a_reset_vec: assert property (p_reset_vec) else $error("reset not at vector 0");

    property p_ext_vec;
        (req_vec[1:0] == 2'b10 && !entry) |=> (irq_vector_ff == 5'h01);
    endproperty
    a_ext_vec: assert property (p_ext_vec) else $error("external vector wrong");

    property p_wdt_vec;
        (req_vec[3:0] == 4'h0 && req_vec[4] && !entry) |=> (irq_vector_ff == 5'h04);
    endproperty
    a_wdt_vec: assert property (p_wdt_vec) else $error("watchdog vector wrong");

    property p_last_vec;
        (req_vec[15:0] == 16'h0000 && req_vec[16] && !entry) |=> (irq_vector_ff == 5'h10);
    endproperty
    a_last_vec: assert property (p_last_vec) else $error("last vector wrong");

    property p_grp_low_set;
        grp_low_hit |=> flags_ff.grp_low;
    endproperty
    a_grp_low_set: assert property (p_grp_low_set) else $error("group low flag missed");

    property p_level_no_flag;
        (sense == 2'b00) |=> !flags_ff.ext;
    endproperty
    a_level_no_flag: assert property (p_level_no_flag) else $error("flag in level mode");

    property p_level_repeat;
        (ext_level_req && !entry) [*2] |=> irq_request_ff;
    endproperty
    a_level_repeat: assert property (p_level_repeat) else $error("level not raised");

    property p_no_io_clk;
        !io_clk_en |=> ($stable(ext_s_ff) && $stable(ext_p_ff));
    endproperty
    a_no_io_clk: assert property (p_no_io_clk) else $error("sampled without io clock");

    property p_fall_edge;
        (io_clk_en && sense == 2'b10 && external_request_line) ##1
        (io_clk_en && !external_request_line) ##1 io_clk_en |=> flags_ff.ext;
    endproperty
    a_fall_edge: assert property (p_fall_edge) else $error("falling edge lost");

    property p_level_wake;
        (!io_clk_en && en_ff.ext && sense == 2'b00 && !external_request_line) |=> wake_ff;
    endproperty
    a_level_wake: assert property (p_level_wake) else $error("level wake missing");

endmodule : epi_top

// File: testbench/epi_core_model.sv
// Purpose: core-side partner that enters offered vectors
// Assumes: one clock; entry pulse launched after a rising edge
// Notes: slow mode lets an offer stand one extra cycle
`timescale 1ns/1ps
module epi_core_model (
    input wire logic clk,
    input wire logic resetn,
    input wire logic slow,
    input wire logic irq_request,
    output logic vector_taken
);
    // ------------------------------------------------------------------
    // vector entry
    // ------------------------------------------------------------------
    logic seen_ff; // offer already seen last cycle
    // never two pulses in a row, so the offer gets its cycle to drop
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            seen_ff <= 1'b0;
            vector_taken <= 1'b0;
        end else begin
            seen_ff <= irq_request & ~vector_taken;
            vector_taken <= irq_request & ~vector_taken & (~slow | seen_ff);
        end
    end
endmodule : epi_core_model

// File: testbench/test_external_pin_interrupt_unit.sv
// Purpose: self-checking bench of the external pin interrupt unit
// Assumes: apb answers in its own time; core model enters vectors
// Notes: one task per scenario
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin num_checks++; if ((got) !== (ex)) begin num_errors++; \
    $display("unexpected %s exp %h got %h", nm, ex, got); end end
module test_external_pin_interrupt_unit;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, err, slow = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, ext_line = 1'b1, io_en = 1'b1, gie = 1'b0, taken;
    logic [11:0] pins = 12'h000;
    logic [3:0] rst_src = 4'h0;
    logic [12:0] periph = 13'h0000;
    logic irq, wake;
    logic [4:0] vec;
    logic [3:0] sleep;
    int num_errors = 0;
    int num_checks = 0;
    localparam logic [7:0] A_CTRL = {epi_pkg::IDX_CTRL, 2'b00};
    localparam logic [7:0] A_EN = {epi_pkg::IDX_ENABLE, 2'b00};
    localparam logic [7:0] A_FLAG = {epi_pkg::IDX_FLAG, 2'b00};
    always #5 clk = ~clk;
    epi_top dut (.clk(clk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .external_request_line(ext_line), .pin_change_inputs(pins),
        .io_clk_en(io_en), .global_int_flag(gie), .vector_taken(taken),
        .reset_sources(rst_src), .peripheral_requests(periph), .irq_request(irq),
        .irq_vector(vec), .wake_request(wake), .sleep_controls(sleep));
    epi_core_model core (.clk(clk), .resetn(resetn), .slow(slow), .irq_request(irq),
        .vector_taken(taken));
    // one apb transfer; holds the request until pready is sampled high
    task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= {24'h000000, d};
        @(posedge clk);
        penable <= 1'b1;
        // no cycle count assumed: only the watchdog ends a hung wait
        do begin @(posedge clk); end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    // wait for the core to enter a vector, then compare it
    task automatic wait_vec(input logic [4:0] ex);
        int n;
        n = 0;
        do begin @(posedge clk); n++; end while (taken !== 1'b1 && n < 60);
        `CHK("taken", 1'b1, taken)
        `CHK("vector", ex, vec)
    endtask : wait_vec
    task automatic t_regs();
        apb(1'b1, A_CTRL, 8'hff);
        apb(1'b0, A_CTRL, 8'h00);
        `CHK("ctrl", epi_pkg::CTRL_RW_MASK, rd);
        `CHK("sleep", 4'hf, sleep);
        apb(1'b1, A_EN, 8'hff);
        apb(1'b0, A_EN, 8'h00);
        `CHK("enable", epi_pkg::GRP_RW_MASK, rd);
        apb(1'b0, 8'h00, 8'h00);
        `CHK("slverr", 1'b1, err);
        apb(1'b1, A_CTRL, 8'h00);
        $display("test regs done");
    endtask : t_regs
    task automatic t_ext();
        logic [1:0] codes [3];
        codes = '{epi_pkg::SENSE_FALL, epi_pkg::SENSE_RISE, epi_pkg::SENSE_ANY};
        gie <= 1'b1;
        apb(1'b1, A_EN, 8'h40);
        foreach (codes[i]) begin
            apb(1'b1, A_CTRL, {6'h00, codes[i]});
            @(posedge clk); // new sense code settled before the pin moves
            ext_line <= &codes[i];
            wait_vec(epi_pkg::VEC_EXT);
        end
        apb(1'b1, A_CTRL, {6'h00, epi_pkg::SENSE_LOW});
        wait_vec(epi_pkg::VEC_EXT);
        wait_vec(epi_pkg::VEC_EXT);
        apb(1'b0, A_FLAG, 8'h00);
        `CHK("ext flag", 1'b0, rd[6]);
        ext_line <= 1'b1; // low was held across several entries
        apb(1'b1, A_EN, 8'h00);
        $display("test ext done");
    endtask : t_ext
    task automatic t_pc();
        apb(1'b1, {epi_pkg::IDX_MASK_LOW, 2'b00}, 8'h01);
        apb(1'b1, {epi_pkg::IDX_MASK_HIGH, 2'b00}, 8'h08);
        apb(1'b1, A_EN, 8'h30);
        io_en <= 1'b0;
        pins <= 12'h001;
        repeat (2) @(posedge clk);
        `CHK("pc wake", 1'b1, wake);
        wait_vec(epi_pkg::VEC_GRP_LOW);
        pins <= 12'h801;
        wait_vec(epi_pkg::VEC_GRP_HIGH);
        // low level with the i/o clock stopped wakes but offers nothing
        apb(1'b1, A_EN, 8'h40);
        ext_line <= 1'b0;
        repeat (2) @(posedge clk);
        `CHK("level wake", 1'b1, wake);
        `CHK("no level irq", 1'b0, irq);
        ext_line <= 1'b1;
        io_en <= 1'b1;
        $display("test pin change done");
    endtask : t_pc
    task automatic t_prio();
        slow <= 1'b1;
        periph <= 13'h1001;
        wait_vec(epi_pkg::VEC_WDT);
        periph <= 13'h1000;
        wait_vec(epi_pkg::VEC_SER_OVF);
        periph <= 13'h0000;
        rst_src <= 4'h2;
        wait_vec(epi_pkg::VEC_RESET);
        rst_src <= 4'h0;
        slow <= 1'b0;
        $display("test priority done");
    endtask : t_prio
    task automatic stop_test();
        $display("checks %0d mismatches %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : stop_test
    initial begin
        repeat (20000) @(posedge clk);
        num_errors++;
        stop_test();
    end
    initial begin
        repeat (5) @(posedge clk);
        resetn <= 1'b1;
        repeat (3) @(posedge clk);
        t_regs();
        t_ext();
        t_pc();
        t_prio();
        stop_test();
    end
endmodule : test_external_pin_interrupt_unit
